// >>> halt_standby_control_test.sv
/* Directed bench for hsc_top.
   Assumes hsc_irq_src as request source and the bound checker. */
`timescale 1ns/1ps
module halt_standby_control_test;
  reg ref_clk = 1'b0, rst_n = 1'b0, hx = 1'b0, fw = 1'b0, mk = 1'b1, rk = 1'b1;
  reg ga = 1'b0, isl = 1'b0, opt = 1'b0, pc = 1'b1, fire = 1'b0, clr = 1'b0;
  reg [2:0] fi = 3'h0, osc = 3'h7, src = 3'h0;
  wire [7:0] irq;
  wire ce, fe, f, m, s, ee, xe, we, be, pe, rh, ph, hl, res, vec, rv;
  integer miscompares = 0, n_compared = 0, n;
  hsc_irq_src i_hsc_irq_src (.ref_clk(ref_clk), .rst_n(rst_n), .fire(fire), .clr(clr),
    .src(src), .vector_take(vec), .irq_pending(irq));
  hsc_top i_hsc_top (.ref_clk(ref_clk), .rst_n(rst_n), .halt_exec(hx), .irq_pending(irq),
    .flag_wr(fw), .flag_idx(fi), .interrupt_mask_flag(mk), .low_high_rank_flag(rk),
    .global_accept_flag(ga), .in_service_level(isl), .fast_osc_on(osc[0]),
    .main_xtal_on(osc[1]), .slow_ring_on(osc[2]), .slow_osc_sw_stop_opt(opt),
    .periph_clk_on(pc), .cpu_clk_en(ce), .flash_en(fe), .fast_internal_osc_clock_en(f),
    .main_crystal_clock_en(m), .slow_ring_clock_en(s), .ext_main_clk_gate_en(ee),
    .watch_crystal_clock_en(xe), .wdt_clk_en(we), .buzzer_en(be), .periph_run_en(pe),
    .ram_hold(rh), .port_hold(ph), .halted(hl), .resume_pulse(res), .vector_take(vec),
    .reset_vector_fetch(rv));
  ////////////////////////////////////////
  task cmp_bit(input string what, input exp, input got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task cmp_dly(input string what, input integer lo, input integer seen);
    n_compared = n_compared + 1;
    if (seen != lo && seen != lo + 1) begin
      miscompares = miscompares + 1;
      $display("Error %s expected %0d or %0d seen %0d", what, lo, lo + 1, seen);
    end
  endtask
  task wrap_up;
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task set_flag(input [2:0] i, input mv, input rv);
    fi = i;
    mk = mv;
    rk = rv;
    fw = 1'b1;
    @(negedge ref_clk) fw = 1'b0;
    @(negedge ref_clk);
  endtask
  // Oscillator and peripheral inputs drop inside halt to prove the osc enables and periph_run_en hold while the buzzer stops
  task halt_run(input [2:0] sv, input g, input i, input ev, input integer lo);
    ga = g;
    isl = i;
    opt = g;
    hx = 1'b1;
    @(negedge ref_clk) hx = 1'b0;
    cmp_bit("cpu_clk_en", 1'b0, ce & fe);
    osc = 3'h0;
    pc = 1'b0;
    @(negedge ref_clk);
    cmp_bit("osc_en", 1'b1, f & m & s & rh & ph);
    cmp_bit("ext_watch_en", 1'b1, ee & xe);
    cmp_bit("wdt_clk_en", !g, we);
    cmp_bit("buzzer_en", 1'b0, be);
    cmp_bit("periph_run_en", 1'b1, pe);
    src = sv;
    fire = 1'b1;
    n = 0;
    while (res !== 1'b1 && n < 40) begin
      @(negedge ref_clk) fire = 1'b0;
      n = n + 1;
    end
    if (lo == 0) begin
      cmp_bit("halted", 1'b1, hl);
    end else begin
      cmp_dly("wake_delay", lo, n - 1);
      cmp_bit("vector_take", ev, vec);
      cmp_bit("cpu_clk_en", 1'b1, ce);
    end
    clr = 1'b1;
    osc = 3'h7;
    pc = 1'b1;
    @(negedge ref_clk) clr = 1'b0;
  endtask
  ////////////////////////////////////////
  initial forever #25 ref_clk = ~ref_clk;
  initial begin
    #100000;
    miscompares = miscompares + 1;
    wrap_up;
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    set_flag(3'h2, 1'b0, 1'b0);
    set_flag(3'h5, 1'b0, 1'b1);
    halt_run(3'h2, 1'b0, 1'b1, 1'b0, 2);
    halt_run(3'h2, 1'b1, 1'b0, 1'b1, 8);
    halt_run(3'h5, 1'b0, 1'b1, 1'b0, 2);
    halt_run(3'h5, 1'b1, 1'b0, 1'b0, 2);
    halt_run(3'h5, 1'b1, 1'b1, 1'b1, 8);
    halt_run(3'h7, 1'b1, 1'b1, 1'b0, 0);
    rst_n = 1'b0;
    @(negedge ref_clk) rst_n = 1'b1;
    @(negedge ref_clk);
    cmp_bit("reset_vector_fetch", 1'b1, rv);
    cmp_bit("halted", 1'b0, hl);
    cmp_bit("cpu_clk_en", 1'b1, ce);
    @(negedge ref_clk);
    cmp_bit("reset_vector_fetch", 1'b0, rv);
    wrap_up;
  end
endmodule // halt_standby_control_test

// >>> hsc_chk.sv
/* Port assertions for hsc_top.
   Assumes one clock and the bind at the foot of this file. */
`timescale 1ns/1ps
`include "hsc_map.vh"
module hsc_chk (
  input wire ref_clk,
  input wire rst_n,
  input wire halt_exec,
  input wire [`HSC_NSRC-1:0] irq_pending,
  input wire slow_osc_sw_stop_opt,
  input wire periph_clk_on,
  input wire cpu_clk_en,
  input wire flash_en,
  input wire fast_internal_osc_clock_en,
  input wire ext_main_clk_gate_en,
  input wire watch_crystal_clock_en,
  input wire wdt_clk_en,
  input wire buzzer_en,
  input wire halted,
  input wire resume_pulse,
  input wire vector_take,
  input wire reset_vector_fetch
);
  // Request seen while halted; wake delays are counted from its first high sample
  wire w = halted & (|irq_pending);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_vec; resume_pulse && vector_take; endsequence
  sequence s_nxt; resume_pulse && !vector_take; endsequence
  sequence s_rvf; reset_vector_fetch ##1 !reset_vector_fetch; endsequence
  ////////////////////////////////////////
  AST_GATE: assert property (halted |-> !cpu_clk_en && !flash_en)
    else $error("cpu clock on in halt");
  AST_FREEZE: assert property (halted && $past(halted) |->
    $stable(fast_internal_osc_clock_en))
    else $error("osc enable moved in halt");
  AST_ON: assert property (ext_main_clk_gate_en && watch_crystal_clock_en)
    else $error("ext or watch clock gated");
  AST_WDT: assert property (halted && $past(halted) &&
    $stable(slow_osc_sw_stop_opt) |-> wdt_clk_en == !slow_osc_sw_stop_opt)
    else $error("watchdog clock wrong");
  AST_BUZZ: assert property ($past(rst_n) |-> buzzer_en == $past(periph_clk_on))
    else $error("buzzer enable wrong");
  AST_ENTRY: assert property (cpu_clk_en && !resume_pulse && halt_exec |=> halted && !cpu_clk_en)
    else $error("halt not entered");
  AST_VEC: assert property (s_vec |-> ($past(w, 8) || $past(w, 9)) && !$past(w, 10))
    else $error("vectored wake delay");
  AST_NXT: assert property (s_nxt |-> ($past(w, 2) || $past(w, 3)) && !$past(w, 4))
    else $error("plain wake delay");
  AST_RST: assert property (!$past(rst_n) |=> cpu_clk_en && !halted)
    else $error("no run after reset");
  AST_RVF: assert property (!$past(rst_n) |=> s_rvf)
    else $error("no single reset vector fetch");
endmodule // hsc_chk
bind hsc_top hsc_chk i_hsc_chk (.ref_clk(ref_clk), .rst_n(rst_n), .halt_exec(halt_exec),
  .irq_pending(irq_pending), .slow_osc_sw_stop_opt(slow_osc_sw_stop_opt),
  .periph_clk_on(periph_clk_on), .cpu_clk_en(cpu_clk_en), .flash_en(flash_en),
  .fast_internal_osc_clock_en(fast_internal_osc_clock_en), .buzzer_en(buzzer_en),
  .ext_main_clk_gate_en(ext_main_clk_gate_en), .wdt_clk_en(wdt_clk_en), .halted(halted),
  .watch_crystal_clock_en(watch_crystal_clock_en), .resume_pulse(resume_pulse),
  .vector_take(vector_take), .reset_vector_fetch(reset_vector_fetch));

// >>> hsc_irq_src.sv
/* Interrupt source model feeding the request flags.
   Assumes bench commands change between clock edges. */
`timescale 1ns/1ps
module hsc_irq_src (
  input wire ref_clk,
  input wire rst_n,
  input wire fire,
  input wire clr,
  input wire [2:0] src,
  input wire vector_take,
  output reg [7:0] irq_pending
);
  // Raises request flags only, never a pin-clocked start
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      irq_pending <= 8'h00;
    else if (clr || vector_take)
      irq_pending <= 8'h00;
    else if (fire)
      irq_pending[src] <= 1'b1;
  end
endmodule // hsc_irq_src

// >>> hsc_map.vh
/*
  Constants for the halt standby controller: state codes, wake delays,
  source count, index width and wake counter width and values.
  Assumes inclusion by bare name from hsc_top.v and hsc_src_mem.v.
*/
// Operation
// - In halt on watch clock, CPU clock gated off; execution and flash stop.
// - Fast osc, main crystal, slow ring keep entry state; RAM and ports held.
// - External main clock follows its pin only; never gated here.
// - Watch crystal keeps running in halt; nothing can stop it.
// - Watchdog clock runs in halt unless software-stoppable slow osc option.
// - Buzzer works in halt but inhibited while peripheral clock stopped.
// - Halt ends once any unmasked interrupt request becomes pending.
// - Wake by interrupt vectors if acceptance enabled, else next instruction.
// - Vectored wake delay is 8 or 9 clocks.
// - Non-vectored wake delay is 2 or 3 clocks.
// - Reset ends halt and proceeds as ordinary reset from reset vector.
// - Request with mask flag 1 never releases halt.
// - Service when global accept 1 and rank 0 or in-service level 1.
`ifndef HSC_MAP_VH
`define HSC_MAP_VH
`define HSC_NSRC 8
`define HSC_IDXW 3
`define HSC_ST_RUN 4'h1
`define HSC_ST_HALT 4'h2
`define HSC_ST_WAKE 4'h4
`define HSC_ST_RSTV 4'h8
`define HSC_CNTW 4
`define HSC_DLY_VEC 4'h8
`define HSC_DLY_NXT 4'h2
`define HSC_CNT_ZERO 4'h0
`define HSC_CNT_ONE 4'h1
`endif

// >>> hsc_src_mem.v
/*
  Per-source flag store: mask and rank flag for each interrupt source,
  written by the core, read through a registered port.
  Assumes one clock and writes only while the CPU runs.
*/
`timescale 1ns/1ps
`include "hsc_map.vh"
module hsc_src_mem (
  input wire ref_clk,
  input wire rst_n,
  input wire wr_en,
  input wire [`HSC_IDXW-1:0] wr_idx,
  input wire wr_mask,
  input wire wr_rank,
  output reg [`HSC_NSRC-1:0] mask_q,
  output reg [`HSC_NSRC-1:0] rank_q
);
  integer i;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Reset masks every source so nothing wakes before software opens it
      mask_q <= {`HSC_NSRC{1'b1}};
      rank_q <= {`HSC_NSRC{1'b1}};
    end else if (wr_en) begin
      for (i = 0; i < `HSC_NSRC; i = i + 1) begin
        if (wr_idx == i[`HSC_IDXW-1:0]) begin
          mask_q[i] <= wr_mask;
          rank_q[i] <= wr_rank;
        end
      end
    end
  end
endmodule // hsc_src_mem

// >>> hsc_top.v
/*
  Halt standby controller for the CPU running on the watch crystal clock:
  gates clocks during halt, decides wake-up path, times the resume.
  Assumes request, flag and option inputs synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "hsc_map.vh"
module hsc_top (
  input wire ref_clk,
  input wire rst_n,
  input wire halt_exec,
  input wire [`HSC_NSRC-1:0] irq_pending,
  input wire flag_wr,
  input wire [`HSC_IDXW-1:0] flag_idx,
  input wire interrupt_mask_flag,
  input wire low_high_rank_flag,
  input wire global_accept_flag,
  input wire in_service_level,
  input wire fast_osc_on,
  input wire main_xtal_on,
  input wire slow_ring_on,
  input wire slow_osc_sw_stop_opt,
  input wire periph_clk_on,
  output reg cpu_clk_en,
  output reg flash_en,
  output reg fast_internal_osc_clock_en,
  output reg main_crystal_clock_en,
  output reg slow_ring_clock_en,
  output reg ext_main_clk_gate_en,
  output reg watch_crystal_clock_en,
  output reg wdt_clk_en,
  output reg buzzer_en,
  output reg periph_run_en,
  output reg ram_hold,
  output reg port_hold,
  output reg halted,
  output reg resume_pulse,
  output reg vector_take,
  output reg reset_vector_fetch
);
  wire [`HSC_NSRC-1:0] mask_q;
  wire [`HSC_NSRC-1:0] rank_q;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [`HSC_CNTW-1:0] cnt;
  reg [`HSC_CNTW-1:0] next_cnt;
  reg vec_sel;
  reg next_vec_sel;
  reg fast_lat;
  reg main_lat;
  reg slow_lat;
  localparam [3:0] ST_RUN = `HSC_ST_RUN;
  localparam [3:0] ST_HALT = `HSC_ST_HALT;
  localparam [3:0] ST_WAKE = `HSC_ST_WAKE;
  localparam [3:0] ST_RSTV = `HSC_ST_RSTV;
  // Last clock of the wake count; resume and vector strobes fire from it
  wire resume_now = (state == ST_WAKE) & (cnt == `HSC_CNT_ONE);
  ////////////////////////////////////////////////////////////////////////////
  hsc_src_mem i_hsc_src_mem (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(flag_wr),
    .wr_idx(flag_idx),
    .wr_mask(interrupt_mask_flag),
    .wr_rank(low_high_rank_flag),
    .mask_q(mask_q),
    .rank_q(rank_q)
  );
  ////////////////////////////////////////////////////////////////////////////
  // A source counts only if pending and unmasked
  function wake_any;
    input [`HSC_NSRC-1:0] req;
    input [`HSC_NSRC-1:0] msk;
    begin
      wake_any = |(req & ~msk);
    end
  endfunction
  // With global accept set, any unmasked source of rank 0 qualifies; rank 1 needs in-service level
  function serve_any;
    input [`HSC_NSRC-1:0] req;
    input [`HSC_NSRC-1:0] msk;
    input [`HSC_NSRC-1:0] rnk;
    input ga;
    input isl;
    begin
      serve_any = ga & (|(req & ~msk & ~rnk) | (isl & |(req & ~msk)));
    end
  endfunction
  wire wake = wake_any(irq_pending, mask_q);
  wire serve = serve_any(irq_pending, mask_q, rank_q, global_accept_flag,
    in_service_level);
  ////////////////////////////////////////////////////////////////////////////
  always @* begin
    next_state = state;
    next_cnt = cnt;
    next_vec_sel = vec_sel;
    case (state)
      ST_RUN: begin
        // Halt is entered even with a wake already pending; ST_HALT leaves it on the next clock
        if (halt_exec) begin
          next_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (wake) begin
          next_state = ST_WAKE;
          next_vec_sel = serve;
          // Count is one short: the cycle spent here adds the last clock
          if (serve) begin
            next_cnt = `HSC_DLY_VEC - `HSC_CNT_ONE;
          end else begin
            next_cnt = `HSC_DLY_NXT - `HSC_CNT_ONE;
          end
        end
      end
      ST_WAKE: begin
        if (cnt == `HSC_CNT_ONE) begin
          next_state = ST_RUN;
          next_cnt = `HSC_CNT_ZERO;
        end else begin
          next_cnt = cnt - `HSC_CNT_ONE;
        end
      end
      ST_RSTV: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
        next_cnt = `HSC_CNT_ZERO;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RSTV;
      cnt <= `HSC_CNT_ZERO;
      vec_sel <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      vec_sel <= next_vec_sel;
    end
  end
  // Oscillator states are latched only while running, so the wake count
  // cannot leak a changed input into the frozen enables
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_lat <= 1'b0;
      main_lat <= 1'b0;
      slow_lat <= 1'b0;
    end else if (state == ST_RUN) begin
      fast_lat <= fast_osc_on;
      main_lat <= main_xtal_on;
      slow_lat <= slow_ring_on;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  wire in_halt = (next_state == ST_HALT) | (next_state == ST_WAKE);
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en <= 1'b0;
      flash_en <= 1'b0;
      fast_internal_osc_clock_en <= 1'b0;
      main_crystal_clock_en <= 1'b0;
      slow_ring_clock_en <= 1'b0;
      ext_main_clk_gate_en <= 1'b1;
      watch_crystal_clock_en <= 1'b1;
      wdt_clk_en <= 1'b0;
      buzzer_en <= 1'b0;
      periph_run_en <= 1'b0;
      ram_hold <= 1'b0;
      port_hold <= 1'b0;
      halted <= 1'b0;
      resume_pulse <= 1'b0;
      vector_take <= 1'b0;
      reset_vector_fetch <= 1'b0;
    end else begin
      cpu_clk_en <= ~in_halt;
      flash_en <= ~in_halt;
      fast_internal_osc_clock_en <= in_halt ? fast_lat : fast_osc_on;
      main_crystal_clock_en <= in_halt ? main_lat : main_xtal_on;
      slow_ring_clock_en <= in_halt ? slow_lat : slow_ring_on;
      // External clock is never gated; the pin alone decides
      ext_main_clk_gate_en <= 1'b1;
      watch_crystal_clock_en <= 1'b1;
      // Option lets software stop the slow osc, so the watchdog loses clock in halt
      wdt_clk_en <= ~(in_halt & slow_osc_sw_stop_opt);
      buzzer_en <= periph_clk_on;
      // Peripherals keep their own clocks; is software's duty
      periph_run_en <= 1'b1;
      ram_hold <= in_halt;
      port_hold <= in_halt;
      halted <= in_halt;
      resume_pulse <= resume_now;
      vector_take <= resume_now & vec_sel;
      // Every reset, from halt or not, leaves through one fetch from the vector
      reset_vector_fetch <= (state == ST_RSTV);
    end
  end
endmodule // hsc_top
